// ---- hdl/slr_defines.vh ----
// constants for the shared lockable ram
`ifndef SLR_DEFINES_VH
`define SLR_DEFINES_VH
`define SLR_DEPTH 256
`define SLR_ADDR_W 8
`define SLR_WORD_W 16
`define SLR_WM_AFTER 2'd0
`define SLR_WM_BEFORE 2'd1
`define SLR_WM_NONE 2'd2
`define SLR_AM_RW 2'd0
`define SLR_AM_RO 2'd1
`define SLR_AM_WO 2'd2
`define SLR_LAT_MIN 2'd1
`define SLR_LAT_MAX 2'd2
`define SLR_INIT_FILL 16'h0000
`define SLR_ST_IDLE 2'd0
`define SLR_ST_GRANT 2'd1
`define SLR_ST_DROP 2'd2
`endif

// ---- hdl/slr_lock.v ----
// lock handshake for one requester
`timescale 1ns/1ps
`default_nettype none
`include "slr_defines.vh"
module slr_lock (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire access_ask,
  output wire access_allowed
);
  reg [1:0] state_q;
  reg [1:0] state_d;
  always @* begin
    state_d = state_q;
    case (state_q)
      `SLR_ST_IDLE: begin
        if (access_ask) begin
          state_d = `SLR_ST_GRANT;
        end
      end
      `SLR_ST_GRANT: begin
        if (!access_ask) begin
          state_d = `SLR_ST_DROP;
        end
      end
      `SLR_ST_DROP: begin
        state_d = `SLR_ST_IDLE;
      end
      default: begin
        state_d = `SLR_ST_IDLE;
      end
    endcase
  end
  always @(posedge clk) begin
    if (rst || !enable) begin
      state_q <= `SLR_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end
  // unprotected memories accept every access, but slr_ram reports access_allowed low
  assign access_allowed = enable ? (state_q == `SLR_ST_GRANT) : 1'b1;
endmodule
`default_nettype wire

// ---- hdl/slr_out_pipe.v ----
// optional second output register stage
`timescale 1ns/1ps
`default_nettype none
`include "slr_defines.vh"
module slr_out_pipe (
  input wire clk,
  input wire rst,
  input wire [1:0] latency,
  input wire [`SLR_WORD_W-1:0] word_in,
  output wire [`SLR_WORD_W-1:0] word_out
);
  reg [`SLR_WORD_W-1:0] stage_q;
  always @(posedge clk) begin
    if (rst) begin
      stage_q <= {`SLR_WORD_W{1'b0}};
    end else begin
      stage_q <= word_in;
    end
  end
  assign word_out = (latency == `SLR_LAT_MAX) ? stage_q : word_in;
endmodule
`default_nettype wire

// ---- hdl/slr_ram.v ----
// shared lockable ram, one port of a pairable memory
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "slr_defines.vh"
module slr_ram #(
  parameter [1:0] WRITE_MODE = `SLR_WM_AFTER,
  parameter [1:0] ACCESS_MODE = `SLR_AM_RW,
  parameter [1:0] LATENCY = 2'd1,
  parameter LOCKABLE = 1,
  parameter INIT_LEN = 4,
  parameter [4*`SLR_WORD_W-1:0] INIT_VEC = 64'h0004_0003_0002_0001
) (
  input wire clk,
  input wire rst,
  input wire [`SLR_ADDR_W-1:0] address,
  input wire [`SLR_WORD_W-1:0] write_word,
  input wire write_enable,
  input wire access_ask,
  output wire access_allowed,
  output wire [`SLR_WORD_W-1:0] read_word
);
  reg [`SLR_WORD_W-1:0] mem [0:`SLR_DEPTH-1];
  reg [`SLR_WORD_W-1:0] rd_q;
  reg [`SLR_WORD_W-1:0] rd_d;
  wire lock_en;
  wire allowed;
  wire can_write;
  wire can_read;
  wire do_write;
  wire [`SLR_WORD_W-1:0] piped;
  integer i;

  assign lock_en = (LOCKABLE != 0);
  slr_lock u_lock (
    .clk(clk),
    .rst(rst),
    .enable(lock_en),
    .access_ask(access_ask),
    .access_allowed(allowed)
  );
  assign access_allowed = lock_en ? allowed : 1'b0;

  assign can_write = (ACCESS_MODE != `SLR_AM_RO);
  assign can_read = (ACCESS_MODE != `SLR_AM_WO);
  assign do_write = write_enable && can_write && allowed;

  // initial image; short list zero-filled, excess never loaded
  initial begin
    for (i = 0; i < `SLR_DEPTH; i = i + 1) begin
      if (i < INIT_LEN && i < 4) begin
        mem[i] = INIT_VEC[i*`SLR_WORD_W +: `SLR_WORD_W];
      end else begin
        mem[i] = `SLR_INIT_FILL;
      end
    end
  end

  always @(posedge clk) begin
    if (do_write) begin
      mem[address] <= write_word;
    end
  end

  always @* begin
    rd_d = rd_q;
    if (!allowed) begin
      rd_d = {`SLR_WORD_W{1'b0}};
    end else if (!write_enable) begin
      rd_d = mem[address];
    end else begin
      case (WRITE_MODE)
        `SLR_WM_AFTER: begin
          rd_d = do_write ? write_word : mem[address];
        end
        `SLR_WM_BEFORE: begin
          rd_d = mem[address];
        end
        `SLR_WM_NONE: begin
          rd_d = rd_q;
        end
        default: begin
          rd_d = mem[address];
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rd_q <= {`SLR_WORD_W{1'b0}};
    end else begin
      rd_q <= rd_d;
    end
  end

  slr_out_pipe u_pipe (
    .clk(clk),
    .rst(rst),
    .latency(LATENCY),
    .word_in(rd_q),
    .word_out(piped)
  );
  assign read_word = can_read ? piped : {`SLR_WORD_W{1'b0}};
endmodule
`default_nettype wire

// ---- verification/slr_ram_bench.sv ----
// ram port bench
`timescale 1ns/1ps
`default_nettype none
module slr_ram_bench;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, want = 1'b0;
  logic [7:0] ad = 8'h0;
  logic [15:0] wd = 16'h0, m [256], q [$];
  wire ask, ok;
  wire [15:0] rd;
  int n_mismatch = 0, n_compared = 0;
  always #50 clk = ~clk;
  slr_requester i_slr_requester (.clk, .want, .access_ask(ask));
  slr_ram i_slr_ram (.clk, .rst, .address(ad), .write_word(wd), .write_enable(we), .access_ask(ask),
    .access_allowed(ok), .read_word(rd));
  task chk(logic [15:0] g, e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t %h %h", $time, g, e);
    end
  endtask
  task op(logic [7:0] a, logic w, logic [15:0] d);
    @(posedge clk);
    ad <= a;
    we <= w;
    wd <= d;
    @(negedge clk);
    if (w && ok) m[a] = d;
    q.push_back(ok ? m[a] : 16'h0);
  endtask
  task lock(logic v);
    @(posedge clk);
    want <= v;
    we <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(16'(ok), 16'(v));
  endtask
  task report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (q.size() > 0) begin
    @(negedge clk);
    chk(rd, q.pop_front());
  end
  initial begin
    #300000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    void'($urandom(29822));
    foreach (m[i]) m[i] = i < 4 ? 16'(i + 1) : 16'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) op(8'(i), !i[0], 16'ha5);
    $display("locked out done");
    lock(1'b1);
    for (int i = 0; i < 24; i++) op(8'(i % 6), 1'($urandom), 16'($urandom));
    $display("access done");
    lock(1'b0);
    op(8'h1, 1'b1, 16'h5a);
    lock(1'b1);
    op(8'h1, 1'b0, 16'h0);
    $display("relock done");
    repeat (2) @(posedge clk);
    report_and_stop;
  end
endmodule
`default_nettype wire

// ---- verification/slr_ram_properties.sv ----
// ram port checker
`timescale 1ns/1ps
`default_nettype none
module slr_ram_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic [15:0] write_word,
  input wire logic write_enable,
  input wire logic access_ask,
  input wire logic access_allowed,
  input wire logic [15:0] read_word
);
  wire a = access_ask;
  wire g = access_allowed;
  wire w = write_enable;
  wire [15:0] r = read_word;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  grant_drop_a: assert property (!a |=> !g) else $error("grant held");
  grant_hold_a: assert property (g && a |=> g) else $error("grant lost");
  grant_soon_a: assert property (a [*3] |-> g) else $error("grant late");
  grant_cause_a: assert property ($rose(g) |-> $past(a)) else $error("grant unasked");
  out_quiet_a: assert property (!g && !$past(g) |-> r == 16'h0) else $error("data leak");
  new_word_a: assert property (g && w |=> !g || r == $past(write_word)) else $error("bad echo");
  kept_word_a: assert property (g && w ##1 g && !w && $stable(address) |=>
    !g || r == $past(write_word, 2)) else $error("not stored");
  read_same_a: assert property (g && !w ##1 g && !w && $stable(address) |=>
    !g || r == $past(r)) else $error("read moved");
  cover property (g && w);
  cover property ($fell(g));
  cover property (a && !g);
endmodule
bind slr_ram slr_ram_checker i_slr_ram_checker (.clk, .rst, .address, .write_word, .write_enable,
  .access_ask, .access_allowed, .read_word);
`default_nettype wire

// ---- verification/slr_requester.sv ----
// requester model for the lock handshake
`timescale 1ns/1ps
`default_nettype none
module slr_requester (
  input wire logic clk,
  input wire logic want,
  output logic access_ask
);
  initial access_ask = 1'b0;
  always @(posedge clk) access_ask <= want;
endmodule
`default_nettype wire
